// ==== inc/bwsr_pkg.sv ====
// Constants and carrier types for the bridge window and secondary status registers
package bwsr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BWSR_OFF_IO_STATUS   = 8'h1c;
  localparam logic [7:0] BWSR_OFF_MEM_WINDOW  = 8'h20;
  localparam logic [7:0] BWSR_OFF_PREF_WINDOW = 8'h24;
  localparam logic [7:0] BWSR_OFF_PREF_HIGH   = 8'h28;
  localparam logic [7:0] BWSR_OFF_BRIDGE_CTRL = 8'h3c;
  localparam int         BWSR_ADDR_BITS       = 8;

  // ----------------------------------------------------------------
  // Field positions and constant codes
  // ----------------------------------------------------------------
  localparam int         BWSR_IO_BASE_LSB    = 4;
  localparam int         BWSR_IO_CAP_LSB     = 8;
  localparam int         BWSR_IO_LIMIT_LSB   = 12;
  localparam logic [1:0] BWSR_IO_CAP_CODE    = 2'h1;
  localparam logic [1:0] BWSR_IO_BASE_CODE   = 2'h1;
  localparam int         BWSR_ST_66MHZ_BIT   = 21;
  localparam int         BWSR_ST_FB2B_BIT    = 23;
  localparam int         BWSR_ST_MPERR_BIT   = 24;
  localparam int         BWSR_ST_SEL_LSB     = 25;
  localparam logic [1:0] BWSR_ST_SEL_CODE    = 2'h1;
  localparam int         BWSR_ST_STA_BIT     = 27;
  localparam int         BWSR_ST_RTA_BIT     = 28;
  localparam int         BWSR_ST_RMA_BIT     = 29;
  localparam int         BWSR_ST_RSE_BIT     = 30;
  localparam int         BWSR_ST_DPE_BIT     = 31;
  localparam int         BWSR_LO_FIELD_LSB   = 4;
  localparam int         BWSR_HI_FIELD_LSB   = 20;
  localparam logic [3:0] BWSR_PREF_CAP_CODE  = 4'h1;
  localparam int         BWSR_PREF_CAP_HI    = 16;
  localparam int         BWSR_CTRL_PERR_BIT  = 16;

  // ----------------------------------------------------------------
  // Reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  BWSR_RST_NIBBLE = 4'h0;
  localparam logic [11:0] BWSR_RST_FIELD  = 12'h000;
  localparam logic [31:0] BWSR_RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]  BWSR_HTRANS_NSQ = 2'h2;
  localparam logic [1:0]  BWSR_HTRANS_SEQ = 2'h3;
  localparam logic        BWSR_HRESP_OKAY = 1'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Secondary bus events, one-cycle pulses from the bus engine
  typedef struct packed {
    logic read_parity_err;     // Parity error on read data or split response
    logic split_wr_parity_msg; // Split completion reports write parity error
    logic sending_write_data;  // Qualifies the parity fault pin
    logic signaled_tgt_abort;
    logic received_tgt_abort;
    logic received_mst_abort;
    logic addr_or_data_perr;
  } bwsr_events_t;

  // Addresses to be tested against the windows
  typedef struct packed {
    logic [63:0] mem_addr;
    logic [31:0] io_addr;
  } bwsr_probe_t;

  // Registered window hits
  typedef struct packed {
    logic io_hit;
    logic mem_hit;
    logic pref_hit;
  } bwsr_hits_t;

endpackage

// ==== hdl/bwsr_regs.sv ====
// Bridge window registers and secondary status register behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - I/O limit bits 9:8 read constant 01, 32-bit I/O addressing.
// - I/O limit bits 15:12 writable, reset zero, low twelve bits implied ones.
// - Secondary status bit 21 reads constant 1, 66 MHz capable.
// - Secondary status bit 23 reads constant 1, fast back-to-back.
// - With parity response enabled, three parity events set status bit 24.
// - Status bits 26:25 read constant 01, medium select timing.
// - Bit 27 sets when we signal target abort as target.
// - Bit 28 sets when, as master, we receive target abort.
// - Bit 29 sets on master abort: nobody claimed our transaction.
// - Bit 30 sets when the system fault pin is sampled low.
// - Bit 31 sets on address or data parity error seen.
// - Memory base bits 15:4 writable, reset zero, bits 3:0 read zero.
// - Memory limit bits 31:20 writable, reset zero, bits 19:16 read zero.
// - Prefetch base 3:0 and limit 19:16 read 0001, 64-bit capable.
// - Prefetch base bits 15:4 writable, reset zero, low bits implied zero.
// - Prefetch limit bits 31:20 writable, reset zero, low bits implied ones.
// - Prefetch base high word fully writable, reset zero, address bits 63:32.
// - Control bit 16 enables secondary parity detection for bit 24, reset zero.
// - I/O base bits 7:4 writable, reset zero, low twelve bits implied zero.
module bwsr_regs
  import bwsr_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Secondary bus side
  input  wire bwsr_events_t events,
  input  wire logic         secondary_parity_fault_pin_n,
  input  wire logic         system_fault_pin_n,
  // Window decode
  input  wire bwsr_probe_t  probe,
  input  wire logic [31:0]  pref_limit_high,
  output bwsr_hits_t        hits,
  output logic              parity_resp_en
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inclusive window test on 64-bit expanded bounds
  function automatic logic in_window(input logic [63:0] addr,
                                     input logic [63:0] lo,
                                     input logic [63:0] hi);
    in_window = (addr >= lo) && (addr <= hi);
  endfunction

  // Offset match on the word-aligned part of the address
  function automatic logic at_offset(input logic [31:0] addr,
                                     input logic [7:0]  off);
    at_offset = (addr[31:BWSR_ADDR_BITS] == '0) &&
                (addr[BWSR_ADDR_BITS-1:2] == off[BWSR_ADDR_BITS-1:2]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0]  io_base_reg;
  logic [3:0]  io_limit_reg;
  logic [11:0] mem_base_reg;
  logic [11:0] mem_limit_reg;
  logic [11:0] pref_base_reg;
  logic [11:0] pref_limit_reg;
  logic [31:0] pref_high_reg;
  logic        perr_en_reg;
  logic        st_mperr_reg;
  logic        st_sta_reg;
  logic        st_rta_reg;
  logic        st_rma_reg;
  logic        st_rse_reg;
  logic        st_dpe_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_off_reg;
  logic [31:0] hrdata_reg;
  bwsr_hits_t  hits_reg;

  logic        addr_phase;
  logic        wr_now;
  logic [31:0] wdata;
  logic [31:0] io_status_word;
  logic [31:0] mem_word;
  logic [31:0] pref_word;
  logic [31:0] ctrl_word;
  logic [31:0] rd_next;
  logic        mperr_event;

  assign addr_phase = hsel && hready && (htrans == BWSR_HTRANS_NSQ || htrans == BWSR_HTRANS_SEQ);
  assign wdata      = hwdata;

  // ----------------------------------------------------------------
  // Bus slave: address phase capture
  // ----------------------------------------------------------------
  // Zero wait states, so hreadyout stays high and every answer is OKAY
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_off_reg  <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= BWSR_HRESP_OKAY;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_off_reg  <= haddr[7:0];
      hreadyout   <= 1'b1;
      hresp       <= BWSR_HRESP_OKAY;
    end
  end

  // Write takes effect at the end of the data phase
  assign wr_now = wr_pend_reg;

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  always_comb begin
    io_status_word = '0;
    io_status_word[BWSR_IO_BASE_LSB +: 4]  = io_base_reg;
    io_status_word[1:0]                    = BWSR_IO_BASE_CODE;
    io_status_word[BWSR_IO_CAP_LSB +: 2]   = BWSR_IO_CAP_CODE;
    io_status_word[BWSR_IO_LIMIT_LSB +: 4] = io_limit_reg;
    io_status_word[BWSR_ST_66MHZ_BIT]      = 1'b1;
    io_status_word[BWSR_ST_FB2B_BIT]       = 1'b1;
    io_status_word[BWSR_ST_MPERR_BIT]      = st_mperr_reg;
    io_status_word[BWSR_ST_SEL_LSB +: 2]   = BWSR_ST_SEL_CODE;
    io_status_word[BWSR_ST_STA_BIT]        = st_sta_reg;
    io_status_word[BWSR_ST_RTA_BIT]        = st_rta_reg;
    io_status_word[BWSR_ST_RMA_BIT]        = st_rma_reg;
    io_status_word[BWSR_ST_RSE_BIT]        = st_rse_reg;
    io_status_word[BWSR_ST_DPE_BIT]        = st_dpe_reg;
    mem_word  = {mem_limit_reg, 4'h0, mem_base_reg, 4'h0};
    pref_word = {pref_limit_reg, BWSR_PREF_CAP_CODE, pref_base_reg, BWSR_PREF_CAP_CODE};
    ctrl_word = '0;
    ctrl_word[BWSR_CTRL_PERR_BIT] = perr_en_reg;
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_next = BWSR_RST_WORD;
    if (at_offset(haddr, BWSR_OFF_IO_STATUS)) begin
      rd_next = io_status_word;
    end else if (at_offset(haddr, BWSR_OFF_MEM_WINDOW)) begin
      rd_next = mem_word;
    end else if (at_offset(haddr, BWSR_OFF_PREF_WINDOW)) begin
      rd_next = pref_word;
    end else if (at_offset(haddr, BWSR_OFF_PREF_HIGH)) begin
      rd_next = pref_high_reg;
    end else if (at_offset(haddr, BWSR_OFF_BRIDGE_CTRL)) begin
      rd_next = ctrl_word;
    end
  end

  // Read data latched in the address phase, so it stands in the data phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata_reg <= BWSR_RST_WORD;
    end else if (addr_phase && !hwrite) begin
      hrdata_reg <= rd_next;
    end
  end
  assign hrdata = hrdata_reg;

  // ----------------------------------------------------------------
  // Writable window fields
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      io_base_reg    <= BWSR_RST_NIBBLE;
      io_limit_reg   <= BWSR_RST_NIBBLE;
      mem_base_reg   <= BWSR_RST_FIELD;
      mem_limit_reg  <= BWSR_RST_FIELD;
      pref_base_reg  <= BWSR_RST_FIELD;
      pref_limit_reg <= BWSR_RST_FIELD;
      pref_high_reg  <= BWSR_RST_WORD;
      perr_en_reg    <= 1'b0;
    end else if (wr_now) begin
      if (at_offset({24'h0, wr_off_reg}, BWSR_OFF_IO_STATUS)) begin
        io_base_reg  <= wdata[BWSR_IO_BASE_LSB +: 4];
        io_limit_reg <= wdata[BWSR_IO_LIMIT_LSB +: 4];
      end
      if (at_offset({24'h0, wr_off_reg}, BWSR_OFF_MEM_WINDOW)) begin
        mem_base_reg  <= wdata[BWSR_LO_FIELD_LSB +: 12];
        mem_limit_reg <= wdata[BWSR_HI_FIELD_LSB +: 12];
      end
      if (at_offset({24'h0, wr_off_reg}, BWSR_OFF_PREF_WINDOW)) begin
        pref_base_reg  <= wdata[BWSR_LO_FIELD_LSB +: 12];
        pref_limit_reg <= wdata[BWSR_HI_FIELD_LSB +: 12];
      end
      if (at_offset({24'h0, wr_off_reg}, BWSR_OFF_PREF_HIGH)) begin
        pref_high_reg <= wdata;
      end
      if (at_offset({24'h0, wr_off_reg}, BWSR_OFF_BRIDGE_CTRL)) begin
        perr_en_reg <= wdata[BWSR_CTRL_PERR_BIT];
      end
    end
  end
  assign parity_resp_en = perr_en_reg;

  // ----------------------------------------------------------------
  // Sticky status flags
  // ----------------------------------------------------------------
  // Parity fault pin only counts while we drive write data; gated by enable
  assign mperr_event = perr_en_reg && (events.read_parity_err || events.split_wr_parity_msg ||
                       (events.sending_write_data && !secondary_parity_fault_pin_n));

  logic st_clear;
  assign st_clear = wr_now && at_offset({24'h0, wr_off_reg}, BWSR_OFF_IO_STATUS);

  // Set wins over a same-cycle one-to-clear, so no event is lost
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_mperr_reg <= 1'b0;
      st_sta_reg   <= 1'b0;
      st_rta_reg   <= 1'b0;
      st_rma_reg   <= 1'b0;
      st_rse_reg   <= 1'b0;
      st_dpe_reg   <= 1'b0;
    end else begin
      st_mperr_reg <= mperr_event ||
                      (st_mperr_reg && !(st_clear && wdata[BWSR_ST_MPERR_BIT]));
      st_sta_reg   <= events.signaled_tgt_abort ||
                      (st_sta_reg && !(st_clear && wdata[BWSR_ST_STA_BIT]));
      st_rta_reg   <= events.received_tgt_abort ||
                      (st_rta_reg && !(st_clear && wdata[BWSR_ST_RTA_BIT]));
      st_rma_reg   <= events.received_mst_abort ||
                      (st_rma_reg && !(st_clear && wdata[BWSR_ST_RMA_BIT]));
      st_rse_reg   <= !system_fault_pin_n ||
                      (st_rse_reg && !(st_clear && wdata[BWSR_ST_RSE_BIT]));
      st_dpe_reg   <= events.addr_or_data_perr ||
                      (st_dpe_reg && !(st_clear && wdata[BWSR_ST_DPE_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  // Expanded bounds: base low bits zero, limit low bits ones
  logic [63:0] io_lo;
  logic [63:0] io_hi;
  logic [63:0] mem_lo;
  logic [63:0] mem_hi;
  logic [63:0] pref_lo;
  logic [63:0] pref_hi;
  assign io_lo   = {48'h0, io_base_reg, 12'h000};
  assign io_hi   = {48'h0, io_limit_reg, 12'hfff};
  assign mem_lo  = {32'h0, mem_base_reg, 20'h00000};
  assign mem_hi  = {32'h0, mem_limit_reg, 20'hfffff};
  assign pref_lo = {pref_high_reg, pref_base_reg, 20'h00000};
  assign pref_hi = {pref_limit_high, pref_limit_reg, 20'hfffff};

  // Registered so the hit outputs come straight from flops, one cycle late
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hits_reg <= '0;
    end else begin
      hits_reg.io_hit   <= in_window({32'h0, probe.io_addr}, io_lo, io_hi);
      hits_reg.mem_hit  <= in_window(probe.mem_addr, mem_lo, mem_hi);
      hits_reg.pref_hit <= in_window(probe.mem_addr, pref_lo, pref_hi);
    end
  end
  assign hits = hits_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_read_io;
    addr_phase && !hwrite && at_offset(haddr, BWSR_OFF_IO_STATUS);
  endsequence

  sequence s_write_status(int b);
    addr_phase && hwrite && at_offset(haddr, BWSR_OFF_IO_STATUS) ##1 wdata[b];
  endsequence

  property p_io_consts;
    @(posedge clock) disable iff (!rst_n)
      s_read_io |=> hrdata[9:8] == 2'h1 && hrdata[26:25] == 2'h1;
  endproperty
  a_io_consts: assert property (p_io_consts) else $error("fixed codes wrong");

  property p_cap_bits;
    @(posedge clock) disable iff (!rst_n)
      s_read_io |=> hrdata[21] && hrdata[23] && hrdata[20:16] == 5'h00;
  endproperty
  a_cap_bits: assert property (p_cap_bits) else $error("capability bits wrong");

  property p_pref_code;
    @(posedge clock) disable iff (!rst_n)
      addr_phase && !hwrite && at_offset(haddr, BWSR_OFF_PREF_WINDOW)
      |=> hrdata[3:0] == 4'h1 && hrdata[19:16] == 4'h1;
  endproperty
  a_pref_code: assert property (p_pref_code) else $error("prefetch code wrong");

  property p_mem_low_zero;
    @(posedge clock) disable iff (!rst_n)
      addr_phase && !hwrite && at_offset(haddr, BWSR_OFF_MEM_WINDOW)
      |=> hrdata[3:0] == 4'h0 && hrdata[19:16] == 4'h0;
  endproperty
  a_mem_low_zero: assert property (p_mem_low_zero) else $error("memory reserved nonzero");

  property p_mperr_gated;
    @(posedge clock) disable iff (!rst_n)
      !st_mperr_reg && !perr_en_reg |=> !st_mperr_reg;
  endproperty
  a_mperr_gated: assert property (p_mperr_gated) else $error("parity flag set while disabled");

  property p_mperr_set;
    @(posedge clock) disable iff (!rst_n)
      perr_en_reg && events.read_parity_err |=> st_mperr_reg;
  endproperty
  a_mperr_set: assert property (p_mperr_set) else $error("parity flag missed");

  property p_rma_set;
    @(posedge clock) disable iff (!rst_n)
      events.received_mst_abort |=> st_rma_reg;
  endproperty
  a_rma_set: assert property (p_rma_set) else $error("master abort flag missed");

  property p_sta_set;
    @(posedge clock) disable iff (!rst_n)
      events.signaled_tgt_abort |=> st_sta_reg;
  endproperty
  a_sta_set: assert property (p_sta_set) else $error("signaled abort flag missed");

  property p_rta_set;
    @(posedge clock) disable iff (!rst_n)
      events.received_tgt_abort |=> st_rta_reg;
  endproperty
  a_rta_set: assert property (p_rta_set) else $error("received abort flag missed");

  property p_dpe_set;
    @(posedge clock) disable iff (!rst_n)
      events.addr_or_data_perr |=> st_dpe_reg;
  endproperty
  a_dpe_set: assert property (p_dpe_set) else $error("parity detected flag missed");

  property p_rse_set;
    @(posedge clock) disable iff (!rst_n)
      $fell(system_fault_pin_n) |=> st_rse_reg;
  endproperty
  a_rse_set: assert property (p_rse_set) else $error("system fault flag missed");

  property p_w1c_clear;
    @(posedge clock) disable iff (!rst_n)
      s_write_status(BWSR_ST_STA_BIT) ##0 !events.signaled_tgt_abort |=> !st_sta_reg;
  endproperty
  a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear");

  property p_sticky_hold;
    @(posedge clock) disable iff (!rst_n)
      st_dpe_reg && !(st_clear && wdata[BWSR_ST_DPE_BIT]) |=> st_dpe_reg [*1];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");

  property p_mem_hit;
    @(posedge clock) disable iff (!rst_n)
      probe.mem_addr[63:32] == 32'h0 && probe.mem_addr[31:20] == mem_limit_reg &&
      mem_base_reg <= mem_limit_reg ##0 $stable(mem_base_reg) |=> hits.mem_hit;
  endproperty
  a_mem_hit: assert property (p_mem_hit) else $error("memory window miss at limit");

  property p_okay;
    @(posedge clock) disable iff (!rst_n)
      addr_phase |=> hreadyout && hresp == BWSR_HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");

endmodule

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking testbench for the bridge window and secondary status registers
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import bwsr_pkg::*;
;
  logic         clock;
  logic         rst_n;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hready;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  bwsr_events_t events;
  logic         perr_n;
  logic         serr_n;
  bwsr_probe_t  probe;
  logic [31:0]  pref_limit_high;
  bwsr_hits_t   hits;
  logic         parity_resp_en;
  logic [31:0]  rd;
  int           fail_count;
  int           tests_run;
  int           cycles;

  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  localparam logic [31:0] ST = 32'h02a0_0101;
  localparam logic [7:0]  OFF [6] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h3c, 8'h40};
  localparam logic [31:0] RST [6] = '{ST, 32'h0, 32'h0001_0001, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] ONE [6] = '{32'h02a0_f1f1, 32'hfff0_fff0, 32'hfff1_fff1,
                                      32'hffff_ffff, 32'h0001_0000, 32'h0};
  localparam logic [6:0]  EV [10] = '{7'h40, 7'h40, 7'h20, 7'h10, 7'h00, 7'h08, 7'h04, 7'h02, 7'h00, 7'h01};
  localparam logic        PN [10] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic        SN [10] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  localparam logic        EN [10] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam logic [31:0] MK [10] = '{32'h0, 32'h0100_0000, 32'h0100_0000, 32'h0100_0000, 32'h0,
                                      32'h0800_0000, 32'h1000_0000, 32'h2000_0000, 32'h4000_0000,
                                      32'h8000_0000};
  localparam logic [63:0] MA [8] = '{64'h0000_0000_1000_0000, 64'h0000_0000_1fff_ffff,
                                     64'h0000_0000_2000_0000, 64'h0000_0000_0fff_ffff,
                                     64'h0000_0001_2000_0000, 64'h0000_0001_3fff_ffff,
                                     64'h0000_0001_4000_0000, 64'h0000_0001_1fff_ffff};
  localparam logic [31:0] IA [8] = '{32'h2000, 32'h3fff, 32'h4000, 32'h1fff, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [2:0]  HT [8] = '{3'h6, 3'h6, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h0};

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;

  bwsr_regs dut (
    .clock                        (clock),
    .rst_n                        (rst_n),
    .hsel                         (hsel),
    .haddr                        (haddr),
    .htrans                       (htrans),
    .hwrite                       (hwrite),
    .hsize                        (hsize),
    .hwdata                       (hwdata),
    .hready                       (hready),
    .hrdata                       (hrdata),
    .hreadyout                    (hreadyout),
    .hresp                        (hresp),
    .events                       (events),
    .secondary_parity_fault_pin_n (perr_n),
    .system_fault_pin_n           (serr_n),
    .probe                        (probe),
    .pref_limit_high              (pref_limit_high),
    .hits                         (hits),
    .parity_resp_en               (parity_resp_en)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Single AHB-Lite word transfer; the slave may stretch either phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= BWSR_HTRANS_NSQ;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, {31'h0, BWSR_HRESP_OKAY});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus({24'h0, a}, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  // One-cycle event pulse with the two fault pins
  task automatic pulse(input logic [6:0] e, input logic pn, input logic sn);
    @(posedge clock);
    events <= bwsr_events_t'(e);
    perr_n <= pn;
    serr_n <= sn;
    @(posedge clock);
    events <= '0;
    perr_n <= 1'b1;
    serr_n <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; events = '0; perr_n = 1'b1; serr_n = 1'b1;
    probe = '0; pref_limit_high = 32'h1; fail_count = 0; tests_run = 0; cycles = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    check({28'h0, hits, parity_resp_en}, 32'h0);
    // Reset values, then all-ones write to show writable and fixed bits
    for (int i = 0; i < 6; i++) begin
      rdchk(OFF[i], RST[i]);
    end
    for (int i = 0; i < 6; i++) begin
      bus({24'h0, OFF[i]}, 1'b1, 32'hffff_ffff);
      rdchk(OFF[i], ONE[i]);
    end
    bus({24'h0, BWSR_OFF_IO_STATUS}, 1'b1, 32'h0);
    // Each event alone; writing zero keeps the flag, writing one clears it
    for (int i = 0; i < 10; i++) begin
      bus({24'h0, BWSR_OFF_BRIDGE_CTRL}, 1'b1, {15'h0, EN[i], 16'h0});
      @(negedge clock);
      check({31'h0, parity_resp_en}, {31'h0, EN[i]});
      pulse(EV[i], PN[i], SN[i]);
      bus({24'h0, BWSR_OFF_IO_STATUS}, 1'b1, 32'h0);
      rdchk(BWSR_OFF_IO_STATUS, ST | MK[i]);
      bus({24'h0, BWSR_OFF_IO_STATUS}, 1'b1, MK[i]);
      rdchk(BWSR_OFF_IO_STATUS, ST);
    end
    // Windows: I/O 2000-3fff, memory 1000_0000-1fff_ffff, prefetch 1_2000_0000-1_3fff_ffff
    bus({24'h0, BWSR_OFF_IO_STATUS}, 1'b1, 32'h0000_3020);
    bus({24'h0, BWSR_OFF_MEM_WINDOW}, 1'b1, 32'h1ff0_1000);
    bus({24'h0, BWSR_OFF_PREF_WINDOW}, 1'b1, 32'h3ff0_2000);
    bus({24'h0, BWSR_OFF_PREF_HIGH}, 1'b1, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      probe <= {MA[i], IA[i]};
      @(posedge clock);
      @(negedge clock);
      check({29'h0, hits}, {29'h0, HT[i]});
    end
    test_done();
  end

endmodule
`default_nettype wire
